// ### cmt_pkg.sv
package cmt_pkg;

  localparam int          num_channels      = 2;
  localparam int          cnt_width         = 16;

  // Register byte offsets, one aligned word each, channel stride 0x10.
  localparam logic [7:0]  off_start         = 8'h00;
  localparam logic [7:0]  off_ctrl_status   = 8'h04;
  localparam logic [7:0]  off_counter       = 8'h08;
  localparam logic [7:0]  off_constant      = 8'h0c;
  localparam logic [7:0]  chan_stride       = 8'h10;
  localparam logic [7:0]  off_irq_status    = 8'h20;
  localparam logic [7:0]  off_irq_mask      = 8'h24;

  // Field positions.
  localparam int          run_bit_pos       = 0;
  localparam int          match_flag_pos    = 7;
  localparam int          req_sel_lo_pos    = 4;
  localparam int          clk_sel_lo_pos    = 0;

  // Reset values.
  localparam logic [15:0] start_reset       = 16'h0000;
  localparam logic [15:0] ctrl_reset        = 16'h0000;
  localparam logic [15:0] counter_reset     = 16'h0000;
  localparam logic [15:0] constant_reset    = 16'hffff;
  localparam logic [3:0]  irq_mask_reset    = 4'h0;

  // Prescaler: divide by 64 needs a 6-bit free-running counter.
  localparam int          presc_width       = 6;

  typedef enum logic [1:0] {
    div_4,
    div_8,
    div_16,
    div_64
  } clk_sel_e;

  typedef enum logic [1:0] {
    req_none,
    req_dma,
    req_irq,
    req_reserved
  } req_sel_e;

  typedef struct packed {
    logic     match_flag;
    req_sel_e req_sel;
    clk_sel_e clk_sel;
  } ctrl_s;

endpackage

// ### cmt_timer.sv
// Added by the designer: the APB slave port and the address map.
module cmt_timer
  import cmt_pkg::*;
(
  // Clock and reset.
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave.
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Per-channel requests.
  output logic      [num_channels-1:0] irq_req,
  output logic      [num_channels-1:0] dma_req,
  input  wire logic [num_channels-1:0] dma_ack,
  // Summary interrupt.
  output logic                         irq
);

  logic [presc_width-1:0]  presc_q;
  logic [num_channels-1:0] run_q;
  ctrl_s                   ctrl_q   [num_channels];
  logic [cnt_width-1:0]    cnt_q    [num_channels];
  logic [cnt_width-1:0]    cor_q    [num_channels];
  logic [num_channels-1:0] flag_seen_q;
  logic [num_channels-1:0] tick;
  logic [num_channels-1:0] match_ev;
  logic [3:0]              irq_stat_q;
  logic [3:0]              irq_mask_q;
  logic [3:0]              stat_set;
  logic [num_channels-1:0] flag_clr;
  logic                    wr_en;
  logic                    rd_en;

  // One prescaler is shared; each channel picks a tap, so channels stay phase related.
  function automatic logic tick_of(input clk_sel_e sel, input logic [presc_width-1:0] p);
    case (sel)
      div_4:   tick_of = (p[1:0] == 2'h3);
      div_8:   tick_of = (p[2:0] == 3'h7);
      div_16:  tick_of = (p[3:0] == 4'hf);
      div_64:  tick_of = (p == 6'h3f);
      default: tick_of = 1'b0;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign wr_en = psel && penable && pwrite;
  // Read side effects happen at the setup edge, where the read data is captured, so the
  // seen latch and the status clear agree with the value that software gets.
  assign rd_en = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 6'h01;
    end
  end

  for (genvar c = 0; c < num_channels; c++) begin : g_ch
    localparam logic [7:0] base = chan_stride * 8'(c);

    assign tick[c]     = run_q[c] && tick_of(ctrl_q[c].clk_sel, presc_q);
    // Equality is acted on at the next counting clock, as the counter reloads.
    assign match_ev[c] = tick[c] && (cnt_q[c] == cor_q[c]);
    assign flag_clr[c] = wr_en && hit(paddr, base + off_ctrl_status) && flag_seen_q[c]
                         && !pwdata[match_flag_pos];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        run_q[c] <= start_reset[0];
      end else if (wr_en && hit(paddr, base + off_start)) begin
        run_q[c] <= pwdata[run_bit_pos];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q[c] <= counter_reset;
      end else if (wr_en && hit(paddr, base + off_counter)) begin
        cnt_q[c] <= pwdata[15:0];
      end else if (match_ev[c]) begin
        cnt_q[c] <= '0;
      end else if (tick[c]) begin
        cnt_q[c] <= cnt_q[c] + 16'h0001;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cor_q[c] <= constant_reset;
      end else if (wr_en && hit(paddr, base + off_constant)) begin
        cor_q[c] <= pwdata[15:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctrl_q[c] <= '{match_flag: ctrl_reset[match_flag_pos],
                       req_sel:    req_sel_e'(ctrl_reset[req_sel_lo_pos +: 2]),
                       clk_sel:    clk_sel_e'(ctrl_reset[clk_sel_lo_pos +: 2])};
      end else begin
        if (wr_en && hit(paddr, base + off_ctrl_status)) begin
          ctrl_q[c].req_sel <= req_sel_e'(pwdata[req_sel_lo_pos +: 2]);
          ctrl_q[c].clk_sel <= clk_sel_e'(pwdata[clk_sel_lo_pos +: 2]);
        end
        // A new match wins over a clear in the same cycle.
        if (match_ev[c]) begin
          ctrl_q[c].match_flag <= 1'b1;
        end else if (flag_clr[c]) begin
          ctrl_q[c].match_flag <= 1'b0;
        end
      end
    end

    // Remembers that software has seen the flag as 1; any flag clear forgets it.
    // A flag that rises after the read data was captured is not counted as seen.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flag_seen_q[c] <= 1'b0;
      end else if (!ctrl_q[c].match_flag || flag_clr[c]) begin
        flag_seen_q[c] <= 1'b0;
      end else if (rd_en && hit(paddr, base + off_ctrl_status)) begin
        flag_seen_q[c] <= 1'b1;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dma_req[c] <= 1'b0;
      end else if (match_ev[c] && ctrl_q[c].req_sel == req_dma) begin
        dma_req[c] <= 1'b1;
      end else if (dma_ack[c]) begin
        dma_req[c] <= 1'b0;
      end
    end

    // The interrupt holds until software clears the flag or sets req_sel to something other than req_irq.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        irq_req[c] <= 1'b0;
      end else if (match_ev[c] && ctrl_q[c].req_sel == req_irq) begin
        irq_req[c] <= 1'b1;
      end else if (flag_clr[c] || ctrl_q[c].req_sel != req_irq) begin
        irq_req[c] <= 1'b0;
      end
    end

    // A counter write in the same cycle takes priority, so the counting checks leave it out.
    property p_reload;
      @(posedge pclk) disable iff (!presetn)
      match_ev[c] && !(wr_en && hit(paddr, base + off_counter)) |=> cnt_q[c] == 16'h0000;
    endproperty
    a_reload: assert property (p_reload)
      else $error("counter did not reload on match");

    property p_count_step;
      @(posedge pclk) disable iff (!presetn)
      tick[c] && !match_ev[c] && !(wr_en && hit(paddr, base + off_counter))
      |=> cnt_q[c] == $past(cnt_q[c]) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step)
      else $error("counter did not step by one on a tick");

    property p_flag_set;
      @(posedge pclk) disable iff (!presetn)
      match_ev[c] |=> ctrl_q[c].match_flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
      else $error("match flag not set");

    property p_no_spurious;
      @(posedge pclk) disable iff (!presetn)
      !ctrl_q[c].match_flag && !match_ev[c] |=> !ctrl_q[c].match_flag;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
      else $error("match flag rose without a match");

    property p_clear_needs_read;
      @(posedge pclk) disable iff (!presetn)
      ctrl_q[c].match_flag && !flag_seen_q[c] && !match_ev[c] |=> ctrl_q[c].match_flag;
    endproperty
    a_clear_needs_read: assert property (p_clear_needs_read)
      else $error("match flag cleared without prior read");

    property p_clear_takes;
      @(posedge pclk) disable iff (!presetn)
      flag_clr[c] && !match_ev[c] |=> !ctrl_q[c].match_flag;
    endproperty
    a_clear_takes: assert property (p_clear_takes)
      else $error("match flag not cleared by a legal clear");

    property p_hold_stopped;
      @(posedge pclk) disable iff (!presetn)
      !run_q[c] && !(wr_en && hit(paddr, base + off_counter)) |=> $stable(cnt_q[c]);
    endproperty
    a_hold_stopped: assert property (p_hold_stopped)
      else $error("counter moved while stopped");

    property p_dma_flag;
      @(posedge pclk) disable iff (!presetn)
      dma_req[c] && dma_ack[c] && !match_ev[c] && !flag_clr[c]
      |=> !dma_req[c] && $stable(ctrl_q[c].match_flag);
    endproperty
    a_dma_flag: assert property (p_dma_flag)
      else $error("dma acceptance mishandled");

    property p_dma_rise;
      @(posedge pclk) disable iff (!presetn)
      match_ev[c] && ctrl_q[c].req_sel == req_dma |=> dma_req[c];
    endproperty
    a_dma_rise: assert property (p_dma_rise)
      else $error("dma request missing after match");

    property p_irq_rise;
      @(posedge pclk) disable iff (!presetn)
      match_ev[c] && ctrl_q[c].req_sel == req_irq |=> irq_req[c] && ctrl_q[c].match_flag;
    endproperty
    a_irq_rise: assert property (p_irq_rise)
      else $error("interrupt request missing after match");

    property p_irq_flag;
      @(posedge pclk) disable iff (!presetn)
      irq_req[c] |-> ctrl_q[c].match_flag;
    endproperty
    a_irq_flag: assert property (p_irq_flag)
      else $error("interrupt request without flag");

    property p_irq_drop;
      @(posedge pclk) disable iff (!presetn)
      irq_req[c] && flag_clr[c] && !match_ev[c] |=> !irq_req[c];
    endproperty
    a_irq_drop: assert property (p_irq_drop)
      else $error("interrupt request held after flag clear");

    property p_no_req;
      @(posedge pclk) disable iff (!presetn)
      match_ev[c] && ctrl_q[c].req_sel inside {req_none, req_reserved} && !dma_req[c]
      && !irq_req[c] |=> !dma_req[c] && !irq_req[c];
    endproperty
    a_no_req: assert property (p_no_req)
      else $error("request raised while requests are disabled");

    property p_div4_rate;
      @(posedge pclk) disable iff (!presetn)
      tick[c] && ctrl_q[c].clk_sel == div_4 && $stable(ctrl_q[c].clk_sel) && run_q[c]
      |=> !tick[c] [*3];
    endproperty
    a_div4_rate: assert property (p_div4_rate)
      else $error("divide-by-4 tick spacing wrong");

    c_match_irq: cover property (@(posedge pclk) disable iff (!presetn)
      match_ev[c] && ctrl_q[c].req_sel == req_irq);
    c_match_dma: cover property (@(posedge pclk) disable iff (!presetn)
      dma_req[c] && dma_ack[c]);
    c_flag_clear: cover property (@(posedge pclk) disable iff (!presetn) flag_clr[c]);
  end

  // Summary status: bits 1:0 interrupt requests seen, bits 3:2 DMA requests seen.
  assign stat_set = {match_ev & {ctrl_q[1].req_sel == req_dma, ctrl_q[0].req_sel == req_dma},
                     match_ev & {ctrl_q[1].req_sel == req_irq, ctrl_q[0].req_sel == req_irq}};

  // A read clears the status, but an event in the same cycle is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else if (rd_en && hit(paddr, off_irq_status)) begin
      irq_stat_q <= stat_set;
    end else begin
      irq_stat_q <= irq_stat_q | stat_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= irq_mask_reset;
    end else if (wr_en && hit(paddr, off_irq_mask)) begin
      irq_mask_q <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Bus and summary interrupt checks.
  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready did not pulse for one access cycle");

  property p_err_reply;
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && (paddr > off_irq_mask || paddr[1:0] != 2'h0)
    |=> pready && pslverr && prdata == 32'h0;
  endproperty
  a_err_reply: assert property (p_err_reply)
    else $error("unmapped access not refused");

  property p_irq_summary;
    @(posedge pclk) disable iff (!presetn)
    irq == |($past(irq_stat_q) & $past(irq_mask_q));
  endproperty
  a_irq_summary: assert property (p_irq_summary)
    else $error("summary interrupt does not follow status and mask");

  c_summary_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

  // Zero-wait-state slave; read data is registered during the setup phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        for (int k = 0; k < num_channels; k++) begin
          if (hit(paddr, chan_stride * 8'(k) + off_start)) begin
            prdata <= {31'h0, run_q[k]};
          end
          if (hit(paddr, chan_stride * 8'(k) + off_ctrl_status)) begin
            prdata <= {24'h0, ctrl_q[k].match_flag, 1'b0, ctrl_q[k].req_sel,
                       2'h0, ctrl_q[k].clk_sel};
          end
          if (hit(paddr, chan_stride * 8'(k) + off_counter)) begin
            prdata <= {16'h0, cnt_q[k]};
          end
          if (hit(paddr, chan_stride * 8'(k) + off_constant)) begin
            prdata <= {16'h0, cor_q[k]};
          end
        end
        if (hit(paddr, off_irq_status)) begin
          prdata <= {28'h0, irq_stat_q};
        end
        if (hit(paddr, off_irq_mask)) begin
          prdata <= {28'h0, irq_mask_q};
        end
        if (paddr > off_irq_mask || paddr[1:0] != 2'h0) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

endmodule // cmt_timer

// ### dma_responder.sv
module dma_responder
  import cmt_pkg::*;
(
  // Clock and reset.
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Request handshake.
  input  wire logic [num_channels-1:0] dma_req,
  output logic      [num_channels-1:0] dma_ack,
  // Cycles to wait before accepting a request.
  input  wire logic [3:0]              lat
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] wait_q [num_channels];

  // A slow controller lets the request stand for several cycles before taking it.
  for (genvar i = 0; i < num_channels; i++) begin : g_ch
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        wait_q[i]  <= 4'h0;
        dma_ack[i] <= 1'b0;
      end else if (dma_req[i] && !dma_ack[i] && wait_q[i] >= lat) begin
        dma_ack[i] <= 1'b1;
        wait_q[i]  <= 4'h0;
      end else begin
        dma_ack[i] <= 1'b0;
        wait_q[i]  <= (dma_req[i] && !dma_ack[i]) ? wait_q[i] + 4'h1 : 4'h0;
      end
    end
  end
endmodule // dma_responder

// ### tb_top.sv
module tb_top
  import cmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, prev_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  irq_req, dma_req, dma_ack;
  logic [3:0]  lat;
  int          fails = 0, total_checks = 0, cyc = 0, rise0 = 0, per0 = 0;
  int          dv [4] = '{4, 8, 16, 64};

  cmt_timer cmt_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_req(irq_req), .dma_req(dma_req), .dma_ack(dma_ack), .irq(irq));
  dma_responder dma_responder_inst (.pclk(pclk), .presetn(presetn), .dma_req(dma_req),
    .dma_ack(dma_ack), .lat(lat));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Match period of channel 0 taken from the rising edges of its DMA request.
  always @(posedge pclk) begin
    cyc    <= cyc + 1;
    prev_q <= dma_req[0];
    if (dma_req[0] === 1'b1 && prev_q === 1'b0) begin
      per0  <= cyc - rise0;
      rise0 <= cyc;
    end
    if (cyc > 20000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps two calls from driving psel twice in one time step.
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    logic [7:0] b;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; lat = 4'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int ch = 0; ch < 2; ch++) begin
      b = chan_stride * ch[7:0];
      rdc(b + off_start, 32'h0);
      rdc(b + off_ctrl_status, 32'h0);
      rdc(b + off_counter, 32'h0);
      rdc(b + off_constant, 32'h0000ffff);
    end
    apb(1'b0, 8'h28, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("reset values done");
    // Unused bits are written as 0; a flag written as one must still read back 0.
    wr(off_start, 32'h00000000);
    rdc(off_start, 32'h0);
    wr(off_ctrl_status, 32'h00000080);
    rdc(off_ctrl_status, 32'h0);
    $display("unused bits done");
    wr(off_constant, 32'h2);
    wr(off_start, 32'h1);
    for (int cs = 0; cs < 4; cs++) begin
      lat <= 4'(cs * 3);
      wr(off_ctrl_status, 32'h10 | cs);
      repeat (dv[cs] * 12 + 20) @(posedge pclk);
      chk(per0, 3 * dv[cs]);
    end
    rdc(off_ctrl_status, 32'h93);
    wr(off_start, 32'h0);
    wr(off_counter, 32'h00001234);
    rdc(off_counter, 32'h00001234);
    rdc(off_constant, 32'h00000002);
    $display("interval and dma done");
    wr(chan_stride + off_constant, 32'h1);
    wr(chan_stride + off_start, 32'h1);
    for (int m = 0; m < 2; m++) begin
      wr(chan_stride + off_ctrl_status, m ? 32'h30 : 32'h0);
      repeat (40) @(posedge pclk);
      chk({irq_req, dma_req}, 32'h0);
    end
    apb(1'b0, off_irq_status, 32'h0);
    wr(off_irq_mask, 32'h2);
    wr(chan_stride + off_ctrl_status, 32'h20);
    repeat (40) @(posedge pclk);
    chk({irq_req, irq}, 32'h5);
    wr(chan_stride + off_start, 32'h0);
    repeat (20) @(posedge pclk);
    chk(irq_req, 32'h2);
    rdc(chan_stride + off_ctrl_status, 32'ha0);
    wr(chan_stride + off_ctrl_status, 32'h20);
    repeat (2) @(posedge pclk);
    chk(irq_req, 32'h0);
    rdc(off_irq_status, 32'h2);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0);
    rdc(off_irq_status, 32'h0);
    $display("interrupt done");
    results();
  end
endmodule // tb_top
